// >>> test/initiator_stream_port_tb_top.sv
// Bench joining device and user ends of the stream port
`timescale 1ns/1ps
module initiator_stream_port_tb_top;
    import isp_pkg::*;
    typedef struct packed {
        logic [ISP_DATA_W-1:0] data;
        logic last;
        logic first;
        logic [ISP_ID_W-1:0] src;
        logic [ISP_ID_W-1:0] dst;
    } isp_beat_type;
    localparam int NPKT = 30;
    logic clock, rst, stall_on;
    logic [31:0] seed;
    int miscompares = 0;
    int n_tests = 0;
    isp_beat_type tx_q[$];
    isp_beat_type rx_q[$];
    logic [ISP_ID_W-1:0] local_device_id, req_dst_id, resp_src_id, resp_dst_id;
    logic [ISP_ID_W-1:0] link_tx_src_id, link_tx_dst_id, link_rx_src_id, link_rx_dst_id;
    logic [ISP_DATA_W-1:0] req_data, resp_data, link_tx_data, link_rx_data;
    logic [ISP_KEEP_W-1:0] req_keep, resp_keep, link_tx_keep, link_rx_keep;
    logic req_valid, req_ready, req_last, req_crf, resp_valid, resp_last, resp_crf;
    logic link_tx_valid, link_tx_last, link_tx_first, link_tx_crf;
    logic link_rx_valid, link_rx_ready, link_rx_last, link_rx_crf;
    logic link_tx_ready = 1'b1;
    logic resp_ready = 1'b1;

    isp_if bus ();
    isp_device_end #(.SHORT_IDS(1'b1)) u_isp_device_end (.clock(clock), .rst(rst),
        .port(bus.device_mp), .link_tx_valid(link_tx_valid), .link_tx_ready(link_tx_ready),
        .link_tx_data(link_tx_data), .link_tx_keep(link_tx_keep), .link_tx_last(link_tx_last),
        .link_tx_first(link_tx_first), .link_tx_src_id(link_tx_src_id),
        .link_tx_dst_id(link_tx_dst_id), .link_tx_crf(link_tx_crf),
        .link_rx_valid(link_rx_valid), .link_rx_ready(link_rx_ready),
        .link_rx_data(link_rx_data), .link_rx_keep(link_rx_keep), .link_rx_last(link_rx_last),
        .link_rx_src_id(link_rx_src_id), .link_rx_dst_id(link_rx_dst_id),
        .link_rx_crf(link_rx_crf));
    isp_user_end #(.SHORT_IDS(1'b1)) u_isp_user_end (.clock(clock), .rst(rst),
        .port(bus.user_mp), .local_device_id(local_device_id), .req_valid(req_valid),
        .req_ready(req_ready), .req_data(req_data), .req_keep(req_keep), .req_last(req_last),
        .req_dst_id(req_dst_id), .req_crf(req_crf), .resp_valid(resp_valid),
        .resp_ready(resp_ready), .resp_data(resp_data), .resp_keep(resp_keep),
        .resp_last(resp_last), .resp_src_id(resp_src_id), .resp_dst_id(resp_dst_id),
        .resp_crf(resp_crf));
    isp_stream_chk #(.SHORT_IDS(1'b1)) u_isp_stream_chk (.clock(clock), .rst(rst),
        .ireq_tvalid(bus.ireq_tvalid), .ireq_tready(bus.ireq_tready),
        .ireq_tdata(bus.ireq_tdata), .ireq_tkeep(bus.ireq_tkeep), .ireq_tlast(bus.ireq_tlast),
        .ireq_tuser(bus.ireq_tuser), .iresp_tvalid(bus.iresp_tvalid),
        .iresp_tready(bus.iresp_tready), .iresp_tdata(bus.iresp_tdata),
        .iresp_tkeep(bus.iresp_tkeep), .iresp_tlast(bus.iresp_tlast),
        .iresp_tuser(bus.iresp_tuser));

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction : rnd

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    // Request packets of one to four beats, held until taken
    task automatic req_stream(input int npkt);
        isp_beat_type e;
        logic [31:0] r;
        for (int p = 0; p < npkt; p++) begin
            r = rnd();
            e.src = {8'h00, local_device_id[7:0]};
            e.dst = {8'h00, r[7:0]};
            req_dst_id = r[15:0];
            req_crf = r[28];
            for (int i = 0; i <= r[25:24]; i++) begin
                e.data = {rnd(), rnd()};
                e.first = (i == 0);
                e.last = (i == r[25:24]);
                req_valid = 1'b1;
                req_data = e.data;
                req_keep = r[23:16];
                req_last = e.last;
                do @(posedge clock); while (req_ready !== 1'b1);
                tx_q.push_back(e);
                @(negedge clock);
            end
            if (r[26]) begin
                req_valid = 1'b0;
                @(negedge clock);
            end
        end
        req_valid = 1'b0;
    endtask : req_stream

    // Response packets arriving from the link
    task automatic rsp_stream(input int npkt);
        isp_beat_type e;
        logic [31:0] r;
        for (int p = 0; p < npkt; p++) begin
            r = rnd();
            e.src = {8'h00, r[7:0]};
            e.dst = {8'h00, r[23:16]};
            link_rx_src_id = r[15:0];
            link_rx_dst_id = r[31:16];
            link_rx_crf = r[12];
            for (int i = 0; i <= r[25:24]; i++) begin
                e.data = {rnd(), rnd()};
                e.first = (i == 0);
                e.last = (i == r[25:24]);
                link_rx_valid = 1'b1;
                link_rx_data = e.data;
                link_rx_keep = seed[7:0];
                link_rx_last = e.last;
                do @(posedge clock); while (link_rx_ready !== 1'b1);
                rx_q.push_back(e);
                @(negedge clock);
            end
            if (r[27]) begin
                link_rx_valid = 1'b0;
                @(negedge clock);
            end
        end
        link_rx_valid = 1'b0;
    endtask : rsp_stream

    // Far-end stalls on both outputs when enabled
    always @(negedge clock) begin : stall_gen
        logic [31:0] r;
        r = rnd();
        link_tx_ready <= !stall_on || r[0];
        resp_ready <= !stall_on || r[1];
    end

    always @(posedge clock) begin : mon_tx
        isp_beat_type e;
        if (!rst && link_tx_valid === 1'b1 && link_tx_ready === 1'b1) begin
            if (tx_q.size() == 0) check(1'b1, 1'b0);
            e = tx_q.pop_front();
            check(link_tx_data, e.data);
            check(link_tx_keep, ISP_KEEP_ALL);
            check(link_tx_last, e.last);
            check(link_tx_first, e.first);
            check(link_tx_src_id, e.src);
            check(link_tx_dst_id, e.dst);
            check(link_tx_crf, 1'b0);
        end
    end

    always @(posedge clock) begin : mon_rx
        isp_beat_type e;
        if (!rst && resp_valid === 1'b1 && resp_ready === 1'b1) begin
            if (rx_q.size() == 0) check(1'b1, 1'b0);
            e = rx_q.pop_front();
            check(resp_data, e.data);
            check(resp_keep, ISP_KEEP_ALL);
            check(resp_last, e.last);
            check(resp_src_id, e.src);
            check(resp_dst_id, e.dst);
            check(resp_crf, 1'b0);
        end
    end

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    initial begin
        #(20 * 20000);
        miscompares++;
        test_done();
    end

    initial begin
        seed = 32'h0000_0866;
        rst = 1'b1;
        stall_on = 1'b0;
        {req_valid, req_last, req_crf, link_rx_valid, link_rx_last, link_rx_crf} = '0;
        {req_data, req_keep, req_dst_id, link_rx_data, link_rx_keep} = '0;
        {link_rx_src_id, link_rx_dst_id} = '0;
        local_device_id = seed[15:0] ^ 16'ha5c3;
        repeat (5) @(negedge clock);
        rst = 1'b0;
        for (int ph = 0; ph < 2; ph++) begin
            stall_on = ph[0];
            fork
                req_stream(NPKT);
                rsp_stream(NPKT);
            join
            @(negedge clock);
        end
        for (int i = 0; i < 200 && (tx_q.size() + rx_q.size()) != 0; i++) @(negedge clock);
        check(tx_q.size() + rx_q.size(), 0);
        test_done();
    end
endmodule : initiator_stream_port_tb_top

// >>> test/isp_stream_chk.sv
// Interface assertions for the initiator stream port
`timescale 1ns/1ps
module isp_stream_chk
    import isp_pkg::*;
#(
    parameter isp_format_type REQ_FORMAT = header_encoded_format,
    parameter isp_format_type RESP_FORMAT = header_encoded_format,
    parameter logic SHORT_IDS = 1'b0
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Request channel
    input wire logic ireq_tvalid,
    input wire logic ireq_tready,
    input wire logic [ISP_DATA_W-1:0] ireq_tdata,
    input wire logic [ISP_KEEP_W-1:0] ireq_tkeep,
    input wire logic ireq_tlast,
    input wire logic [ISP_USER_W-1:0] ireq_tuser,
    // Response channel
    input wire logic iresp_tvalid,
    input wire logic iresp_tready,
    input wire logic [ISP_DATA_W-1:0] iresp_tdata,
    input wire logic [ISP_KEEP_W-1:0] iresp_tkeep,
    input wire logic iresp_tlast,
    input wire logic [ISP_USER_W-1:0] iresp_tuser
);
    logic req_first_reg;
    logic resp_first_reg;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            req_first_reg <= 1'b1;
            resp_first_reg <= 1'b1;
        end else begin
            if (ireq_tvalid && ireq_tready) req_first_reg <= ireq_tlast;
            if (iresp_tvalid && iresp_tready) resp_first_reg <= iresp_tlast;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_req_hold;
        ireq_tvalid && !ireq_tready |=>
            ireq_tvalid && $stable(ireq_tdata) && $stable(ireq_tlast) && $stable(ireq_tuser);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request beat moved early");
    property p_resp_hold;
        iresp_tvalid && !iresp_tready |=>
            iresp_tvalid && $stable(iresp_tdata) && $stable(iresp_tlast) && $stable(iresp_tuser);
    endproperty
    a_resp_hold: assert property (p_resp_hold) else $error("response beat moved early");
    property p_req_drop;
        $fell(ireq_tvalid) |-> $past(ireq_tready);
    endproperty
    a_req_drop: assert property (p_req_drop) else $error("request valid dropped early");
    property p_resp_drop;
        $fell(iresp_tvalid) |-> $past(iresp_tready);
    endproperty
    a_resp_drop: assert property (p_resp_drop) else $error("response valid dropped");
    property p_req_keep;
        ireq_tvalid && REQ_FORMAT == header_encoded_format |-> ireq_tkeep == ISP_KEEP_ALL;
    endproperty
    a_req_keep: assert property (p_req_keep) else $error("request keep not all ones");
    property p_resp_keep;
        iresp_tvalid && RESP_FORMAT == header_encoded_format |-> iresp_tkeep == ISP_KEEP_ALL;
    endproperty
    a_resp_keep: assert property (p_resp_keep) else $error("response keep not all ones");
    property p_req_ids;
        ireq_tvalid && req_first_reg && SHORT_IDS |->
            ireq_tuser[31:24] == 8'h00 && ireq_tuser[15:8] == 8'h00;
    endproperty
    a_req_ids: assert property (p_req_ids) else $error("request id not padded");
    property p_resp_ids;
        iresp_tvalid && resp_first_reg && SHORT_IDS |->
            iresp_tuser[31:24] == 8'h00 && iresp_tuser[15:8] == 8'h00;
    endproperty
    a_resp_ids: assert property (p_resp_ids) else $error("response id not padded");
    property p_req_later;
        ireq_tvalid && !req_first_reg |-> ireq_tuser == '0;
    endproperty
    a_req_later: assert property (p_req_later) else $error("late request sideband");
    property p_resp_later;
        iresp_tvalid && !resp_first_reg |-> iresp_tuser == '0;
    endproperty
    a_resp_later: assert property (p_resp_later) else $error("response sideband later");

    c_req_b2b: cover property (ireq_tvalid && ireq_tready ##1 ireq_tvalid && ireq_tready);
    c_resp_stall: cover property (iresp_tvalid && !iresp_tready);
    c_req_multi: cover property (ireq_tvalid && ireq_tready && !ireq_tlast);
endmodule : isp_stream_chk

// >>> verilog/isp_device_end.sv
// Core end: takes requests toward the link, delivers link responses
`timescale 1ns/1ps
module isp_device_end
    import isp_pkg::*;
#(
    parameter isp_format_type REQ_FORMAT = header_encoded_format,
    parameter isp_format_type RESP_FORMAT = header_encoded_format,
    parameter logic SHORT_IDS = 1'b0,
    parameter logic CRF_ENABLE = 1'b1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,

    // Stream channels to the user design
    isp_if.device_mp port,

    // Outgoing requests toward the link
    output logic link_tx_valid,
    input wire logic link_tx_ready,
    output logic [ISP_DATA_W-1:0] link_tx_data,
    output logic [ISP_KEEP_W-1:0] link_tx_keep,
    // Packet marks
    output logic link_tx_last,
    output logic link_tx_first,
    // Sideband per packet
    output logic [ISP_ID_W-1:0] link_tx_src_id,
    output logic [ISP_ID_W-1:0] link_tx_dst_id,
    output logic link_tx_crf,

    // Incoming responses from the link
    input wire logic link_rx_valid,
    output logic link_rx_ready,
    input wire logic [ISP_DATA_W-1:0] link_rx_data,
    input wire logic [ISP_KEEP_W-1:0] link_rx_keep,
    // Packet mark
    input wire logic link_rx_last,
    // First-beat sideband
    input wire logic [ISP_ID_W-1:0] link_rx_src_id,
    input wire logic [ISP_ID_W-1:0] link_rx_dst_id,
    input wire logic link_rx_crf
);
    typedef struct packed {
        // Request beat waiting for the link
        logic tx_valid;
        logic [ISP_DATA_W-1:0] tx_data;
        logic [ISP_KEEP_W-1:0] tx_keep;
        logic tx_last;
        logic tx_first;
        logic [ISP_ID_W-1:0] tx_src;
        logic [ISP_ID_W-1:0] tx_dst;
        logic tx_crf;

        // Response beat waiting for the user
        logic rx_valid;
        logic [ISP_DATA_W-1:0] rx_data;
        logic [ISP_KEEP_W-1:0] rx_keep;
        logic rx_last;
        logic [ISP_USER_W-1:0] rx_user;
    } isp_dev_state_type;

    // One slice per direction
    isp_dev_state_type state_reg;
    isp_dev_state_type state_next;

    // Boundary flags
    logic req_first;
    logic rsp_first;

    // Handshake terms
    logic req_ready;
    logic rsp_ready;
    logic req_take;
    logic rsp_take;

    // Offered sideband
    logic [ISP_USER_W-1:0] req_user;

    // Slot frees when empty or draining this cycle
    // Ready never reads valid: no loop
    assign req_ready = !state_reg.tx_valid || link_tx_ready;
    assign rsp_ready = !state_reg.rx_valid || port.iresp_tready;
    assign req_take = port.ireq_tvalid && req_ready;
    assign rsp_take = link_rx_valid && rsp_ready;
    assign req_user = port.ireq_tuser;

    // Packet boundary on the request channel
    isp_first_tracker req_tracker (
        .clock(clock),
        .rst(rst),
        .beat_valid(port.ireq_tvalid),
        .beat_ready(req_ready),
        .beat_last(port.ireq_tlast),
        .first(req_first)
    );

    // Packet boundary on the incoming link stream
    isp_first_tracker rsp_tracker (
        .clock(clock),
        .rst(rst),
        .beat_valid(link_rx_valid),
        .beat_ready(rsp_ready),
        .beat_last(link_rx_last),
        .first(rsp_first)
    );

    always_comb begin
        // Hold by default
        state_next = state_reg;

        // Request path
        // Drain first; a same-cycle take wins
        if (state_reg.tx_valid && link_tx_ready) begin
            state_next.tx_valid = 1'b0;
        end
        if (req_take) begin
            state_next.tx_valid = 1'b1;
            state_next.tx_data = port.ireq_tdata;
            state_next.tx_keep = isp_keep_fn(REQ_FORMAT, port.ireq_tlast,
                port.ireq_tkeep);
            state_next.tx_last = port.ireq_tlast;
            state_next.tx_first = req_first;

            if (req_first) begin
                // Sideband read on the first beat only
                if (REQ_FORMAT == header_encoded_format) begin
                    state_next.tx_src = isp_id_fn(SHORT_IDS,
                        req_user[ISP_SRC_LSB +: ISP_ID_W]);
                    state_next.tx_dst = isp_id_fn(SHORT_IDS,
                        req_user[ISP_DST_LSB +: ISP_ID_W]);
                    state_next.tx_crf = 1'b0;
                end else begin
                    // No IDs in raw format
                    state_next.tx_src = '0;
                    state_next.tx_dst = '0;
                    state_next.tx_crf = req_user[ISP_CRF_BIT] && CRF_ENABLE;
                end
            end
        end

        // Response path
        if (state_reg.rx_valid && port.iresp_tready) begin
            state_next.rx_valid = 1'b0;
        end
        if (rsp_take) begin
            state_next.rx_valid = 1'b1;
            state_next.rx_data = link_rx_data;
            state_next.rx_keep = isp_keep_fn(RESP_FORMAT, link_rx_last,
                link_rx_keep);
            state_next.rx_last = link_rx_last;

            // IDs on the opening beat only
            if (rsp_first) begin
                state_next.rx_user = isp_user_fn(RESP_FORMAT, SHORT_IDS,
                    link_rx_src_id, link_rx_dst_id,
                    link_rx_crf && CRF_ENABLE);
            end else begin
                // Reserved on later beats
                state_next.rx_user = '0;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            // Slices start empty
            state_reg.tx_valid <= 1'b0;
            state_reg.tx_data <= '0;
            state_reg.tx_keep <= ISP_KEEP_ALL;
            state_reg.tx_last <= 1'b0;
            state_reg.tx_first <= 1'b0;
            state_reg.tx_src <= '0;
            state_reg.tx_dst <= '0;
            state_reg.tx_crf <= 1'b0;

            state_reg.rx_valid <= 1'b0;
            state_reg.rx_data <= '0;
            state_reg.rx_keep <= ISP_KEEP_ALL;
            state_reg.rx_last <= 1'b0;
            state_reg.rx_user <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Request channel answer
    assign port.ireq_tready = req_ready;

    // Beats toward the link
    assign link_tx_valid = state_reg.tx_valid;
    assign link_tx_data = state_reg.tx_data;
    assign link_tx_keep = state_reg.tx_keep;
    assign link_tx_last = state_reg.tx_last;
    assign link_tx_first = state_reg.tx_first;
    assign link_tx_src_id = state_reg.tx_src;
    assign link_tx_dst_id = state_reg.tx_dst;
    assign link_tx_crf = state_reg.tx_crf;

    // Link stream answer
    assign link_rx_ready = rsp_ready;

    // Response channel, held until taken
    assign port.iresp_tvalid = state_reg.rx_valid;
    assign port.iresp_tdata = state_reg.rx_data;
    assign port.iresp_tkeep = state_reg.rx_keep;
    assign port.iresp_tlast = state_reg.rx_last;
    assign port.iresp_tuser = state_reg.rx_user;
endmodule : isp_device_end

// >>> verilog/isp_first_tracker.sv
// First-beat flag for one stream channel
`timescale 1ns/1ps
module isp_first_tracker (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Observed handshake
    input wire logic beat_valid,
    input wire logic beat_ready,
    input wire logic beat_last,
    // Next accepted beat opens a packet
    output logic first
);
    typedef struct packed {
        logic first;
    } isp_trk_state_type;

    isp_trk_state_type state_reg;
    isp_trk_state_type state_next;

    always_comb begin
        state_next = state_reg;
        if (beat_valid && beat_ready) begin
            state_next.first = beat_last;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg.first <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign first = state_reg.first;
endmodule : isp_first_tracker

// >>> verilog/isp_if.sv
// Initiator request and response stream channels between core and user
`timescale 1ns/1ps
interface isp_if
    import isp_pkg::*;
();
    // Request channel, user to core
    logic ireq_tvalid;
    logic ireq_tready;
    logic [ISP_DATA_W-1:0] ireq_tdata;
    logic [ISP_KEEP_W-1:0] ireq_tkeep;
    logic ireq_tlast;
    logic [ISP_USER_W-1:0] ireq_tuser;
    // Response channel, core to user
    logic iresp_tvalid;
    logic iresp_tready;
    logic [ISP_DATA_W-1:0] iresp_tdata;
    logic [ISP_KEEP_W-1:0] iresp_tkeep;
    logic iresp_tlast;
    logic [ISP_USER_W-1:0] iresp_tuser;

    modport device_mp (
        input ireq_tvalid, ireq_tdata, ireq_tkeep, ireq_tlast, ireq_tuser,
        output ireq_tready,
        output iresp_tvalid, iresp_tdata, iresp_tkeep, iresp_tlast, iresp_tuser,
        input iresp_tready
    );
    modport user_mp (
        output ireq_tvalid, ireq_tdata, ireq_tkeep, ireq_tlast, ireq_tuser,
        input ireq_tready,
        input iresp_tvalid, iresp_tdata, iresp_tkeep, iresp_tlast, iresp_tuser,
        output iresp_tready
    );
endinterface : isp_if

// >>> verilog/isp_pkg.sv
// Shared constants, format type and sideband helpers for the stream port
// How it works
// - Beat moves when valid and ready both high
// - Response valid marks every held response beat
// - Beats are 64 bits, header then payload
// - Header format requests keep all ones
// - Raw format requests keep ones except last
// - Keep bit 7 top byte, bit 0 bottom
// - Last marker only on final packet beat
// - Header sideband: source high, destination low
// - Short IDs zero their upper byte
// - Request source ID comes from local ID
// - Raw request sideband bit 1 is critical flag
// - Sideband only meaningful on first beat
// - Header format responses keep all ones
// - Raw responses keep ones except last beat
// - Raw response bit 1 carries critical flag
// - Accepted requests forwarded toward the link
// - Link responses delivered on response channel
package isp_pkg;
    localparam int ISP_DATA_W = 64;
    localparam int ISP_KEEP_W = 8;
    localparam int ISP_USER_W = 32;
    localparam int ISP_ID_W = 16;
    localparam int ISP_SHORT_ID_W = 8;
    localparam int ISP_SRC_LSB = 16;
    localparam int ISP_DST_LSB = 0;
    localparam int ISP_CRF_BIT = 1;
    localparam logic [ISP_KEEP_W-1:0] ISP_KEEP_ALL = 8'hff;

    typedef enum logic [0:0] {
        header_encoded_format = 1'b0,
        raw_packet_stream_format = 1'b1
    } isp_format_type;

    // Keep qualifier as carried on a channel
    function automatic logic [ISP_KEEP_W-1:0] isp_keep_fn(
        input isp_format_type fmt,
        input logic last,
        input logic [ISP_KEEP_W-1:0] keep
    );
        if (fmt == raw_packet_stream_format && last) begin
            return keep;
        end
        return ISP_KEEP_ALL;
    endfunction : isp_keep_fn

    function automatic logic [ISP_ID_W-1:0] isp_id_fn(
        input logic short_ids,
        input logic [ISP_ID_W-1:0] id
    );
        if (short_ids) begin
            return {{(ISP_ID_W-ISP_SHORT_ID_W){1'b0}}, id[ISP_SHORT_ID_W-1:0]};
        end
        return id;
    endfunction : isp_id_fn

    // First-beat sideband word
    function automatic logic [ISP_USER_W-1:0] isp_user_fn(
        input isp_format_type fmt,
        input logic short_ids,
        input logic [ISP_ID_W-1:0] src,
        input logic [ISP_ID_W-1:0] dst,
        input logic critical_request_flag
    );
        logic [ISP_USER_W-1:0] u;
        u = '0;
        if (fmt == header_encoded_format) begin
            u[ISP_SRC_LSB +: ISP_ID_W] = isp_id_fn(short_ids, src);
            u[ISP_DST_LSB +: ISP_ID_W] = isp_id_fn(short_ids, dst);
        end else begin
            u[ISP_CRF_BIT] = critical_request_flag;
        end
        return u;
    endfunction : isp_user_fn
endpackage : isp_pkg

// >>> verilog/isp_user_end.sv
// User end: issues requests and consumes responses on the stream port
`timescale 1ns/1ps
module isp_user_end
    import isp_pkg::*;
#(
    parameter isp_format_type REQ_FORMAT = header_encoded_format,
    parameter isp_format_type RESP_FORMAT = header_encoded_format,
    parameter logic SHORT_IDS = 1'b0,
    parameter logic CRF_ENABLE = 1'b1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Stream channels to the core
    isp_if.user_mp port,
    // Local identity
    input wire logic [ISP_ID_W-1:0] local_device_id,
    // Requests from user logic
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [ISP_DATA_W-1:0] req_data,
    input wire logic [ISP_KEEP_W-1:0] req_keep,
    input wire logic req_last,
    input wire logic [ISP_ID_W-1:0] req_dst_id,
    input wire logic req_crf,
    // Responses to user logic
    output logic resp_valid,
    input wire logic resp_ready,
    output logic [ISP_DATA_W-1:0] resp_data,
    output logic [ISP_KEEP_W-1:0] resp_keep,
    output logic resp_last,
    output logic [ISP_ID_W-1:0] resp_src_id,
    output logic [ISP_ID_W-1:0] resp_dst_id,
    output logic resp_crf
);
    typedef struct packed {
        logic q_valid;
        logic [ISP_DATA_W-1:0] q_data;
        logic [ISP_KEEP_W-1:0] q_keep;
        logic q_last;
        logic [ISP_USER_W-1:0] q_user;
        logic r_valid;
        logic [ISP_DATA_W-1:0] r_data;
        logic [ISP_KEEP_W-1:0] r_keep;
        logic r_last;
        logic [ISP_ID_W-1:0] r_src;
        logic [ISP_ID_W-1:0] r_dst;
        logic r_crf;
    } isp_usr_state_type;

    isp_usr_state_type state_reg;
    isp_usr_state_type state_next;

    logic q_first;
    logic r_first;
    logic q_open;
    logic r_open;
    logic [ISP_USER_W-1:0] rsp_user;

    assign q_open = !state_reg.q_valid || port.ireq_tready;
    assign r_open = !state_reg.r_valid || resp_ready;
    assign rsp_user = port.iresp_tuser;

    isp_first_tracker q_tracker (
        .clock(clock),
        .rst(rst),
        .beat_valid(req_valid),
        .beat_ready(q_open),
        .beat_last(req_last),
        .first(q_first)
    );

    isp_first_tracker r_tracker (
        .clock(clock),
        .rst(rst),
        .beat_valid(port.iresp_tvalid),
        .beat_ready(r_open),
        .beat_last(port.iresp_tlast),
        .first(r_first)
    );

    always_comb begin
        state_next = state_reg;
        if (state_reg.q_valid && port.ireq_tready) begin
            state_next.q_valid = 1'b0;
        end
        if (req_valid && q_open) begin
            state_next.q_valid = 1'b1;
            state_next.q_data = req_data;
            state_next.q_keep = isp_keep_fn(REQ_FORMAT, req_last, req_keep);
            state_next.q_last = req_last;
            state_next.q_user = q_first ? isp_user_fn(REQ_FORMAT, SHORT_IDS,
                local_device_id, req_dst_id,
                req_crf && CRF_ENABLE) : '0;
        end
        if (state_reg.r_valid && resp_ready) begin
            state_next.r_valid = 1'b0;
        end
        if (port.iresp_tvalid && r_open) begin
            state_next.r_valid = 1'b1;
            state_next.r_data = port.iresp_tdata;
            state_next.r_keep = port.iresp_tkeep;
            state_next.r_last = port.iresp_tlast;
            if (r_first) begin
                if (RESP_FORMAT == header_encoded_format) begin
                    state_next.r_src = rsp_user[ISP_SRC_LSB +: ISP_ID_W];
                    state_next.r_dst = rsp_user[ISP_DST_LSB +: ISP_ID_W];
                    state_next.r_crf = 1'b0;
                end else begin
                    state_next.r_crf = rsp_user[ISP_CRF_BIT];
                end
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign req_ready = q_open;
    assign port.ireq_tvalid = state_reg.q_valid;
    assign port.ireq_tdata = state_reg.q_data;
    assign port.ireq_tkeep = state_reg.q_keep;
    assign port.ireq_tlast = state_reg.q_last;
    assign port.ireq_tuser = state_reg.q_user;
    assign port.iresp_tready = r_open;
    assign resp_valid = state_reg.r_valid;
    assign resp_data = state_reg.r_data;
    assign resp_keep = state_reg.r_keep;
    assign resp_last = state_reg.r_last;
    assign resp_src_id = state_reg.r_src;
    assign resp_dst_id = state_reg.r_dst;
    assign resp_crf = state_reg.r_crf;
endmodule : isp_user_end
